// ==== rtl/psr_entry_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module psr_entry_fifo
  import psr_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = 2
) (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              flush_in,
  input  wire logic              push_in,
  input  wire logic [WIDTH-1:0]  data_in,
  input  wire logic              pop_in,
  output logic [WIDTH-1:0]       head_out,
  output logic                   empty_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic [PW-1:0]     rd_ptr;
  logic [PW-1:0]     wr_ptr;
  logic [PW:0]       count;
  logic              full;
  logic              pop_ok;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign full = (count == (PW+1)'(DEPTH));
  assign pop_ok = pop_in && count != '0;
  assign head_out = mem[rd_ptr];
  assign empty_out = (count == '0);

  // storage: a push into a full store drops the oldest entry
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (push_in && !flush_in) begin
      mem[wr_ptr] <= data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || flush_in) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      if (push_in) begin
        wr_ptr <= nxt(wr_ptr);
      end
      if (pop_ok || (push_in && full)) begin
        rd_ptr <= nxt(rd_ptr);
      end
      if (push_in && !full && !pop_ok) begin
        count <= count + 1'b1;
      end else if (pop_ok && !push_in) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/psr_manchester_rx.sv ====
`timescale 1ns/1ns
`default_nettype none
module psr_manchester_rx
  import psr_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              enable_in,
  input  wire logic              fast_in,
  input  wire logic              long_in,
  input  wire logic              line_in,
  output logic                   done_out,
  output logic                   invalid_out,
  output logic [DATA_W-1:0]      data_out
);
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BITS = 1'b1} psr_rx_state_t;
  psr_rx_state_t       state;
  logic                line_q;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    bit_cyc;
  logic [CNT_W-1:0]    early;
  logic [CNT_W-1:0]    late;
  logic [3:0]          nb;
  logic [3:0]          nb_exp;
  logic [12:0]         sr;
  logic                half_seen;
  logic                err_time;
  logic                err_many;
  logic                edge_seen;
  logic                bad_frame;
  logic [DATA_W-1:0]   payload;

  // windows around the expected mid-bit edge: 3/4 to 5/4 of a bit
  assign bit_cyc = fast_in ? CNT_W'(BIT_CYC_FAST) : CNT_W'(BIT_CYC_SLOW);
  assign early = bit_cyc - (bit_cyc >> 2);
  assign late = bit_cyc + (bit_cyc >> 2);
  assign nb_exp = long_in ? 4'(FRAME_LONG) : 4'(FRAME_SHORT);
  assign edge_seen = line_in ^ line_q;
  // bits arrive lsb first; short data lands right-justified
  assign payload = long_in ? sr[11:2] : {2'h0, sr[11:4]};
  assign bad_frame = err_time | err_many | (nb != nb_exp)
    | (long_in ? ^sr[12:2] : ^sr[12:4])
    | (long_in ? |sr[1:0] : |sr[3:2]);

  always_ff @(posedge sys_clk_in) begin
    line_q <= sys_rst_in ? 1'b1 : line_in;
  end

  // frame walk: first edge is the mid-bit of the first start bit
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= RX_IDLE;
      cnt <= '0;
      nb <= 4'h0;
      sr <= 13'h0000;
      half_seen <= 1'b0;
      err_time <= 1'b0;
      err_many <= 1'b0;
      done_out <= 1'b0;
      invalid_out <= 1'b0;
      data_out <= '0;
    end else begin
      done_out <= 1'b0;
      cnt <= cnt + 1'b1;
      if (!enable_in) begin
        state <= RX_IDLE;
      end else begin
        unique case (state)
          RX_IDLE: if (edge_seen) begin
            state <= RX_BITS;
            cnt <= '0;
            nb <= 4'h1;
            sr <= {line_in, 12'h000};
            half_seen <= 1'b0;
            err_time <= 1'b0;
            err_many <= 1'b0;
          end
          RX_BITS: if (cnt > late) begin
            // silence past the window ends the frame
            state <= RX_IDLE;
            done_out <= 1'b1;
            invalid_out <= bad_frame;
            data_out <= payload;
          end else if (edge_seen && cnt < early) begin
            err_time <= err_time | half_seen; // two boundary edges in one bit
            half_seen <= 1'b1;
          end else if (edge_seen) begin
            cnt <= '0;
            half_seen <= 1'b0;
            if (nb == nb_exp) begin
              err_many <= 1'b1;
            end else begin
              nb <= nb + 1'b1;
              sr <= {line_in, sr[12:1]};
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/psr_pkg.sv ====
package psr_pkg;
  // register port map
  localparam int REG_AW = 5;
  localparam int REG_DW = 32;
  localparam logic [4:0] ADDR_SWITCH = 5'h00;
  localparam logic [4:0] ADDR_CFG0 = 5'h04;
  localparam logic [4:0] ADDR_DATA0 = 5'h0C;
  localparam logic [4:0] ADDR_FSUM = 5'h14;
  localparam logic [4:0] ADDR_GSW = 5'h18;
  localparam int NCH = 2;
  // entry layout
  localparam int ENTRY_W = 20;
  localparam int DATA_W = 10;
  localparam int LOGICAL_CHANNEL_ID_W = 4;
  localparam int POS_LOGICAL_CHANNEL_ID = 10;
  localparam int POS_FLT = 15;
  localparam int POS_CHON = 16;
  localparam int FLAG_W = 5;
  localparam int FLG_STG = 0;
  localparam int FLG_INVALID = 5;
  localparam int FLG_EMPTY = 6;
  // config, switch and status fields
  localparam int CFG_W = 6;
  localparam int CFG_RATE = 0;
  localparam int CFG_SIZE = 1;
  localparam int CFG_LOGICAL_CHANNEL_ID = 2;
  localparam logic [5:0] CFG_RESET = 6'h02;
  localparam logic [1:0] SWITCH_RESET = 2'h0;
  localparam int GSW_FAULT = 0;
  localparam int GSW_EMPTY = 1;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BIT_NS_SLOW = 8000;
  localparam int BIT_NS_FAST = 5291;
  localparam int BIT_CYC_SLOW = BIT_NS_SLOW * (CLK_HZ / 1_000_000) / 1000;
  localparam int BIT_CYC_FAST = BIT_NS_FAST * (CLK_HZ / 1_000_000) / 1000;
  localparam int CNT_W = 9;
  localparam int FRAME_LONG = 13;
  localparam int FRAME_SHORT = 11;
  localparam logic [2:0] CRC_SEED = 3'h7;

  function automatic logic [2:0] psr_crc3(input logic [16:0] d);
    logic [2:0] s;
    logic [2:0] c;
    s = CRC_SEED;
    c[2] = s[0]^d[0]^d[1]^d[3]^d[6]^d[7]^d[8]^d[10]^d[13]^d[14]^d[15];
    c[1] = s[2]^d[0]^d[1]^d[2]^d[4]^d[7]^d[8]^d[9]^d[11]^d[14]^d[15]^d[16];
    c[0] = s[1]^s[0]^d[0]^d[2]^d[5]^d[6]^d[7]^d[9]^d[12]^d[13]^d[14]^d[16];
    return c;
  endfunction

  function automatic logic [ENTRY_W-1:0] psr_entry(input logic chon, input logic flt,
      input logic [LOGICAL_CHANNEL_ID_W-1:0] logical_channel_id, input logic [DATA_W-1:0] pay);
    logic [16:0] d;
    d = {chon, flt, 1'b0, logical_channel_id, pay};
    return {psr_crc3(d), d};
  endfunction

  function automatic logic [DATA_W-1:0] psr_flags(input logic [FLAG_W-1:0] f,
      input logic inv, input logic emp);
    logic [DATA_W-1:0] p;
    p = '0;
    p[FLG_STG +: FLAG_W] = f;
    p[FLG_INVALID] = inv;
    p[FLG_EMPTY] = emp;
    return p;
  endfunction

  function automatic logic [REG_AW-1:0] psr_cfg_addr(input int ch);
    return ADDR_CFG0 + REG_AW'(ch << 2);
  endfunction

  function automatic logic [REG_AW-1:0] psr_data_addr(input int ch);
    return ADDR_DATA0 + REG_AW'(ch << 2);
  endfunction
endpackage

// ==== rtl/psr_sensor_receiver.sv ====
`timescale 1ns/1ns
`default_nettype none
// Function
// - two independent receive channels
// - host switches channels, reads on status
// - two-entry store behind one address
// - first read oldest, next newest
// - keep last two messages, valid or not
// - fault flushes; resume after clear and read
// - error entry sets fault bit, flags
// - fault sets global bit, else empty flag
// - read clears; then empty answer
// - entry updates whole in one cycle
// - Manchester at 125 or 189 kbps
// - 8 or 10 data bits plus parity
// - bit error discards the message
// - invalid is length, parity, timing OR
// - channel fault clears invalid, empty flags
// - 4-bit channel id heads each entry
// - 3-bit CRC over bits 16 to 0
// - CRC polynomial 1+x+x^3, seed 111
// - CRC bit 2 equation
// - CRC bits 1, 0 equations
// - reject glitches under quarter bit
// - exactly 13 (10-bit) or 11 (8-bit) mid-bit transitions expected
// - 8-bit data right-justified
module psr_sensor_receiver
  import psr_pkg::*;
#(
  parameter int NUM_CH = NCH,
  parameter int DEPTH  = 2
) (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [REG_AW-1:0] reg_addr_in,
  input  wire logic [REG_DW-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [REG_DW-1:0]      reg_rdata_out,
  input  wire logic [NUM_CH-1:0] sensor_current_in,
  input  wire logic [NUM_CH-1:0] short_ground_in,
  input  wire logic [NUM_CH-1:0] short_battery_in,
  input  wire logic [NUM_CH-1:0] high_current_in,
  input  wire logic [NUM_CH-1:0] open_load_in,
  input  wire logic [NUM_CH-1:0] overtemp_in,
  output logic [NUM_CH-1:0]      channel_supply_en_out
);
  // channel switch and on status
  logic [NUM_CH-1:0]          chan_en;
  logic [NUM_CH-1:0]          chan_on;
  logic [NUM_CH-1:0]          chan_block;

  // per channel configuration
  logic [CFG_W-1:0]           cfg [NUM_CH];

  // per channel latched faults, flattened for the summary
  logic [NUM_CH*FLAG_W-1:0]   fsum_flat;

  // entry shown on a data read
  logic [ENTRY_W-1:0]         rd_entry [NUM_CH];

  // events feeding the global status word
  logic [NUM_CH-1:0]          fault_evt;
  logic [NUM_CH-1:0]          empty_evt;

  // global status word
  logic [1:0]                 global_status_word;

  // decoded strobes
  logic                       fsum_rd;
  logic                       gsw_rd;
  logic                       switch_wr;

  assign fsum_rd = reg_rd_in && reg_addr_in == ADDR_FSUM;
  assign gsw_rd = reg_rd_in && reg_addr_in == ADDR_GSW;
  assign switch_wr = reg_wr_in && reg_addr_in == ADDR_SWITCH;

  // channel switch register
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      chan_en <= NUM_CH'(SWITCH_RESET);
    end else if (switch_wr) begin
      chan_en <= reg_wdata_in[NUM_CH-1:0];
    end
  end

  // a channel is operational while switched on and not held off by faults
  assign chan_on = chan_en & ~chan_block;

  // one full receive path per channel; they share only the register strobes, so one summary read clears both
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [5:0]          sync_a;
    logic [5:0]          sync_b;
    logic [FLAG_W-1:0]   live;
    logic                any_live;
    logic [FLAG_W-1:0]   flt_q;
    logic                faulted;
    logic                filt;
    logic [CNT_W-1:0]    gcnt;
    logic [CNT_W-1:0]    glim;
    logic                dec_done;
    logic                dec_inv;
    logic [DATA_W-1:0]   dec_data;
    logic                push;
    logic [ENTRY_W-1:0]  push_entry;
    logic                data_rd;
    logic                pop;
    logic                fifo_empty;
    logic [ENTRY_W-1:0]  head;
    logic [LOGICAL_CHANNEL_ID_W-1:0]   logical_channel_id;

    // pins cross in through two flops before anything looks at them
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        sync_a <= 6'h00;
        sync_b <= 6'h00;
      end else begin
        sync_a <= {overtemp_in[g], open_load_in[g], high_current_in[g],
                   short_battery_in[g], short_ground_in[g],
                   sensor_current_in[g]};
        sync_b <= sync_a;
      end
    end

    assign live = sync_b[5:1];
    assign any_live = |live;
    assign logical_channel_id = cfg[g][CFG_LOGICAL_CHANNEL_ID +: LOGICAL_CHANNEL_ID_W];

    // configuration register of this channel
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        cfg[g] <= CFG_RESET;
      end else if (reg_wr_in && reg_addr_in == psr_cfg_addr(g)) begin
        cfg[g] <= reg_wdata_in[CFG_W-1:0];
      end
    end

    // glitch length limit follows the selected rate
    assign glim = cfg[g][CFG_RATE] ? CNT_W'(BIT_CYC_FAST >> 2)
                                   : CNT_W'(BIT_CYC_SLOW >> 2);

    // the current level must hold a quarter bit before it is believed;
    // this delays every edge equally, so bit windows are not skewed
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        filt <= 1'b1;
        gcnt <= '0;
      end else if (sync_b[0] == filt) begin
        gcnt <= '0;
      end else if (gcnt >= glim - 1'b1) begin
        filt <= sync_b[0];
        gcnt <= '0;
      end else begin
        gcnt <= gcnt + 1'b1;
      end
    end

    psr_manchester_rx u_rx (
      .sys_clk_in  (sys_clk_in),
      .sys_rst_in  (sys_rst_in),
      .enable_in   (chan_on[g]),
      .fast_in     (cfg[g][CFG_RATE]),
      .long_in     (cfg[g][CFG_SIZE]),
      .line_in     (filt),
      .done_out    (dec_done),
      .invalid_out (dec_inv),
      .data_out    (dec_data)
    );

    // faults stick until the summary is read with the condition gone;
    // a fault present in the read cycle wins over the clear
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        flt_q <= '0;
      end else begin
        flt_q <= live | (flt_q & ~{FLAG_W{fsum_rd}});
      end
    end

    assign faulted = |flt_q;

    // reception stays off until faults are gone and the flag was read
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        chan_block[g] <= 1'b0;
      end else begin
        chan_block[g] <= any_live | (chan_block[g] & ~fsum_rd);
      end
    end

    // bad frames are kept as error entries, their data thrown away
    assign push = dec_done && chan_on[g];
    assign push_entry = dec_inv
      ? psr_entry(1'b1, 1'b1, logical_channel_id, psr_flags('0, 1'b1, 1'b0))
      : psr_entry(1'b1, 1'b0, logical_channel_id, dec_data);

    assign data_rd = reg_rd_in && reg_addr_in == psr_data_addr(g);
    assign pop = data_rd && !faulted && !fifo_empty;

    psr_entry_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (DEPTH)
    ) u_fifo (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .flush_in   (any_live || !chan_en[g]),
      .push_in    (push),
      .data_in    (push_entry),
      .pop_in     (pop),
      .head_out   (head),
      .empty_out  (fifo_empty)
    );

    // answer to a data read: faults first, then empty, then the oldest
    always_comb begin
      if (faulted) begin
        rd_entry[g] = psr_entry(chan_on[g], 1'b1, logical_channel_id,
                                psr_flags(flt_q, 1'b0, 1'b0));
      end else if (fifo_empty) begin
        rd_entry[g] = psr_entry(chan_on[g], 1'b1, logical_channel_id,
                                psr_flags('0, 1'b0, 1'b1));
      end else begin
        rd_entry[g] = head;
      end
    end

    assign fsum_flat[g*FLAG_W +: FLAG_W] = flt_q;
    assign fault_evt[g] = any_live || (push && dec_inv);
    assign empty_evt[g] = data_rd && !faulted && fifo_empty;

    // drivers stay off after short to ground or overtemperature
    always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
        channel_supply_en_out[g] <= 1'b0;
      end else begin
        channel_supply_en_out[g] <= chan_en[g] && !flt_q[0] && !flt_q[4];
      end
    end
  end

  // global status: sticky, cleared by its read, a new event wins
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      global_status_word <= 2'h0;
    end else begin
      global_status_word[GSW_FAULT] <= (global_status_word[GSW_FAULT] && !gsw_rd) || |fault_evt;
      global_status_word[GSW_EMPTY] <= (global_status_word[GSW_EMPTY] && !gsw_rd) || |empty_evt;
    end
  end

  // read data stand in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= '0;
      if (reg_rd_in) begin
        if (reg_addr_in == ADDR_SWITCH) begin
          reg_rdata_out <= REG_DW'({chan_on, chan_en});
        end
        if (reg_addr_in == ADDR_FSUM) begin
          reg_rdata_out <= REG_DW'(fsum_flat);
        end
        if (reg_addr_in == ADDR_GSW) begin
          reg_rdata_out <= REG_DW'(global_status_word);
        end
        for (int c = 0; c < NUM_CH; c++) begin
          if (reg_addr_in == psr_cfg_addr(c)) begin
            reg_rdata_out <= REG_DW'(cfg[c]);
          end
          if (reg_addr_in == psr_data_addr(c)) begin
            reg_rdata_out <= REG_DW'(rd_entry[c]);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/psr_sensor_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module psr_sensor_model
  import psr_pkg::*;
(
  input  wire logic sys_clk_in,
  output logic      line_out
);
  // idle level is high, so the first edge of a frame is a mid-bit edge
  initial line_out = 1'b1;

  // one half bit; the level moves just after a rising edge
  task automatic half(input logic lvl, input int cyc);
    line_out <= lvl;
    repeat (cyc) @(posedge sys_clk_in);
  endtask

  // lsb first after the start bits; bad_par only when a scenario asks for it
  task automatic send(input logic [DATA_W-1:0] data, input int nbits, input int bitc,
      input logic bad_par);
    logic [FRAME_LONG-1:0] bits;
    bits = '0; // both start bits stay zero
    for (int i = 0; i < nbits; i++) bits[i+2] = data[i];
    bits[nbits+2] = (^data) ^ bad_par; // even parity
    @(posedge sys_clk_in);
    for (int i = 0; i < nbits + 3; i++) begin
      half(~bits[i], bitc / 2);
      half(bits[i], bitc - bitc / 2); // value is the level after mid-bit
    end
    half(1'b1, bitc); // gap before any next frame
    half(1'b0, bitc / 8); // short glitch in the gap must be dropped
    half(1'b1, bitc);
  endtask
endmodule
`default_nettype wire

// ==== testbench/psr_sensor_receiver_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module psr_sensor_receiver_chk
  import psr_pkg::*;
#(
  parameter int NUM_CH = NCH,
  parameter int DEPTH  = 2
) (
  input wire logic              sys_clk_in,
  input wire logic              sys_rst_in,
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [REG_DW-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [REG_DW-1:0] reg_rdata_out,
  input wire logic [NUM_CH-1:0] sensor_current_in,
  input wire logic [NUM_CH-1:0] short_ground_in,
  input wire logic [NUM_CH-1:0] short_battery_in,
  input wire logic [NUM_CH-1:0] high_current_in,
  input wire logic [NUM_CH-1:0] open_load_in,
  input wire logic [NUM_CH-1:0] overtemp_in,
  input wire logic [NUM_CH-1:0] channel_supply_en_out
);
  logic [NUM_CH-1:0] sw_q;
  logic              hard_flt;

  // masks hold the bit lists of each check bit; all seed bits are one
  function automatic logic [2:0] crc_of(input logic [16:0] d);
    return {~^(d & 17'h0E5CB), ~^(d & 17'h1CB97), ^(d & 17'h172E5)};
  endfunction

  // switch shadow, and a sticky mark of faults that may hold channel 0 down
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sw_q     <= SWITCH_RESET;
      hard_flt <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == ADDR_SWITCH) sw_q <= reg_wdata_in[NUM_CH-1:0];
      if (short_ground_in[0] || overtemp_in[0]) hard_flt <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (reg_rd_in && (reg_addr_in[1:0] != 2'h0
    || reg_addr_in > ADDR_GSW) |=> reg_rdata_out == '0) else $error("unmapped read not zero");
  a_switch_back: assert property (reg_rd_in && reg_addr_in == ADDR_SWITCH |=>
    reg_rdata_out[1:0] == $past(sw_q) && reg_rdata_out[31:4] == '0) else $error("switch readback");
  a_supply_gated: assert property ((channel_supply_en_out & ~$past(sw_q)) == '0)
    else $error("supply on for a switched off channel");
  a_supply_on: assert property (reg_wr_in && reg_addr_in == ADDR_SWITCH && reg_wdata_in[0]
    && !hard_flt |-> ##[1:4] channel_supply_en_out[0]) else $error("supply did not follow switch");
  a_ground_cut: assert property (short_ground_in[0] [*4] |-> ##[1:6] !channel_supply_en_out[0])
    else $error("supply kept on a grounded channel");
  a_fault_entry: assert property (open_load_in[0] [*6] ##0 (reg_rd_in &&
    reg_addr_in == ADDR_DATA0) |=> reg_rdata_out[POS_FLT] && reg_rdata_out[FLG_STG+3]
    && !reg_rdata_out[FLG_INVALID] && !reg_rdata_out[FLG_EMPTY]) else $error("fault entry");
  a_entry_crc: assert property ($past(reg_rd_in) && ($past(reg_addr_in) == ADDR_DATA0
    || $past(reg_addr_in) == ADDR_DATA0 + 5'h04) |-> reg_rdata_out[31:20] == '0
    && reg_rdata_out[19:17] == crc_of(reg_rdata_out[16:0])) else $error("entry crc wrong");

  c_valid_read: cover property ($past(reg_rd_in && reg_addr_in == ADDR_DATA0)
    && !reg_rdata_out[POS_FLT]);
  c_empty_read: cover property ($past(reg_rd_in) && reg_rdata_out[FLG_EMPTY]);
  c_supply_cut: cover property ($fell(channel_supply_en_out[0]));
endmodule

bind psr_sensor_receiver psr_sensor_receiver_chk #(.NUM_CH(NUM_CH), .DEPTH(DEPTH)) i_psr_chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .sensor_current_in(sensor_current_in),
  .short_ground_in(short_ground_in), .short_battery_in(short_battery_in),
  .high_current_in(high_current_in), .open_load_in(open_load_in),
  .overtemp_in(overtemp_in), .channel_supply_en_out(channel_supply_en_out));
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  import psr_pkg::*;

  typedef struct {
    string       name;
    logic [31:0] exp;
    logic [31:0] mask;
  } psr_note_t;

  localparam logic [31:0] M_ALL = 32'hFFFFFFFF;
  localparam logic [31:0] M_ENT = 32'hFFF1FFFF; // crc is judged by the checker
  localparam logic [31:0] M_FLT = 32'hFFF0FFFF; // on bit open while a fault holds
  localparam logic [4:0]  A_D1  = ADDR_DATA0 + 5'h04;

  logic              sys_clk_in;
  logic              sys_rst_in;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [REG_DW-1:0] reg_rdata;
  logic              line0;
  logic              line1;
  logic [NCH-1:0]    supply_en;
  logic [4:0]        flt0;
  logic              rd_q;
  logic [3:0]        id0;
  logic [3:0]        id1;
  logic [9:0]        d0[3];
  logic [9:0]        d1;
  psr_note_t         note;
  psr_note_t         notes[$];
  integer            seed;
  int                errors;
  int                n_compared;

  psr_sensor_receiver i_psr_sensor_receiver (
    .sys_clk_in           (sys_clk_in),
    .sys_rst_in           (sys_rst_in),
    .reg_addr_in          (reg_addr),
    .reg_wdata_in         (reg_wdata),
    .reg_wr_in            (reg_wr),
    .reg_rd_in            (reg_rd),
    .reg_rdata_out        (reg_rdata),
    .sensor_current_in    ({line1, line0}),
    .short_ground_in      ({1'b0, flt0[0]}),
    .short_battery_in     ({1'b0, flt0[1]}),
    .high_current_in      ({1'b0, flt0[2]}),
    .open_load_in         ({1'b0, flt0[3]}),
    .overtemp_in          ({1'b0, flt0[4]}),
    .channel_supply_en_out(supply_en)
  );
  psr_sensor_model i_sens0 (.sys_clk_in(sys_clk_in), .line_out(line0));
  psr_sensor_model i_sens1 (.sys_clk_in(sys_clk_in), .line_out(line1));

  // 20 MHz system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one idle edge after each strobe, so no strobe is assigned twice at one edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input string name, input logic [4:0] a, input logic [31:0] e,
      input logic [31:0] m);
    notes.push_back('{name, e & m, m});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  function automatic logic [31:0] ent(input logic on, input logic flt, input logic [3:0] id,
      input logic [9:0] pay);
    return {15'h0000, on, flt, 1'b0, id, pay};
  endfunction

  // channel 0 runs 10-bit slow frames, channel 1 8-bit fast ones
  task automatic frm(input int ch, input logic [9:0] d, input logic bad);
    if (ch == 0) i_sens0.send(d, 10, BIT_CYC_SLOW, bad);
    else i_sens1.send(d, 8, BIT_CYC_FAST, bad);
  endtask

  // read data stand only in the cycle after the strobe; judged mid-cycle
  always @(posedge sys_clk_in) rd_q <= reg_rd;
  always @(negedge sys_clk_in) begin
    if (rd_q && notes.size() > 0) begin
      note = notes.pop_front();
      cmp(note.name, note.exp, reg_rdata & note.mask);
    end
  end

  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    errors++;
    $display("ERROR run limit expected end seen hang");
    conclude();
  end

  initial begin
    sys_rst_in = 1'b1;
    reg_addr   = '0;
    reg_wdata  = '0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    flt0       = '0;
    seed       = 32'h6de5284c;
    id0        = 4'($random(seed));
    id1        = 4'($random(seed));
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd("switch", ADDR_SWITCH, 32'h0, M_ALL);
    rd("config", A_D1 - 5'h08, {26'h0, CFG_RESET}, M_ALL);
    rd("unmapped", 5'h1C, 32'h0, M_ALL);
    wr(ADDR_CFG0, {26'h0, id0, 2'b10});
    wr(ADDR_CFG0 + 5'h04, {26'h0, id1, 2'b01});
    wr(ADDR_SWITCH, 32'h3);
    repeat (4) @(posedge sys_clk_in);
    cmp("supply", 32'h3, 32'(supply_en));
    rd("switch", ADDR_SWITCH, 32'hF, M_ALL);
    rd("empty entry", ADDR_DATA0, ent(1, 1, id0, 10'h040), M_ENT);
    rd("status", ADDR_GSW, 32'h2, M_ALL);
    $display("test registers and empty read done");
    for (int i = 0; i < 3; i++) d0[i] = 10'($random(seed));
    d1 = {2'b00, 8'($random(seed))};
    fork
      begin
        frm(0, d0[0], 1'b0);
        frm(0, d0[1], 1'b0);
        frm(0, d0[2], 1'b1);
      end
      frm(1, d1, 1'b0);
    join
    rd("oldest", ADDR_DATA0, ent(1, 0, id0, d0[1]), M_ENT);
    rd("newest invalid", ADDR_DATA0, ent(1, 1, id0, 10'h020), M_ENT);
    rd("drained", ADDR_DATA0, ent(1, 1, id0, 10'h040), M_ENT);
    rd("short word", A_D1, ent(1, 0, id1, d1), M_ENT);
    rd("status", ADDR_GSW, 32'h3, M_ALL);
    $display("test order and overwrite done");
    for (int k = 0; k < 5; k++) begin
      frm(0, 10'($random(seed)), 1'b0);
      d1 = {2'b00, 8'($random(seed))};
      fork
        frm(1, d1, 1'b0);
        begin
          repeat (200) @(posedge sys_clk_in);
          flt0[k] <= 1'b1;
          repeat (8) @(posedge sys_clk_in);
          rd("fault entry", ADDR_DATA0, ent(1, 1, id0, 10'(1 << k)), M_FLT);
          flt0[k] <= 1'b0;
          repeat (4) @(posedge sys_clk_in);
          rd("fault summary", ADDR_FSUM, 32'(1 << k), M_ALL);
          rd("status", ADDR_GSW, 32'h1, M_ALL);
          rd("flushed", ADDR_DATA0, ent(1, 1, id0, 10'h040), M_FLT);
          rd("status", ADDR_GSW, 32'h2, M_ALL);
        end
      join
      rd("other channel", A_D1, ent(1, 0, id1, d1), M_ENT);
      wr(ADDR_SWITCH, 32'h2);
      wr(ADDR_SWITCH, 32'h3);
    end
    $display("test channel faults done");
    d0[0] = 10'($random(seed));
    frm(0, d0[0], 1'b0);
    rd("resumed", ADDR_DATA0, ent(1, 0, id0, d0[0]), M_ENT);
    $display("test resume done");
    conclude();
  end
endmodule
`default_nettype wire
